//--- rtl/uie_pkg.sv
// constants, field positions and enumerations shared by both endpoint ends
// assumes one clock and byte-wide control/status registers
package uie_pkg;
   typedef logic [7:0] uie_byte_t;

   localparam logic [31:0] ADDR_INDEX   = 32'h44A00178;
   localparam logic [31:0] ADDR_MAX_PKT = 32'h44A00180;
   localparam logic [31:0] ADDR_CSR_A   = 32'h44A00184;
   localparam logic [31:0] ADDR_CSR_B   = 32'h44A00188;

   // in_endpoint_ctrl_status_a fields
   localparam int B_TOG   = 6;
   localparam int B_SSENT = 5;
   localparam int B_SREQ  = 4;
   localparam int B_FLUSH = 3;
   localparam int B_UNDER = 2;
   localparam int B_RDY   = 0;
   // in_endpoint_ctrl_status_b fields
   localparam int B_AUTO   = 7;
   localparam int B_ISO    = 6;
   localparam int B_DIR    = 5;
   localparam int B_DMAOFF = 4;

   localparam uie_byte_t RST_CSR_A   = 8'h00;
   localparam uie_byte_t RST_CSR_B   = 8'h20;
   localparam uie_byte_t RST_MAX_PKT = 8'h01;
   localparam uie_byte_t RST_INDEX   = 8'h00;

   typedef enum logic [1:0] {D_IDLE, D_SEND, D_WAIT, D_FLUSH} uie_dstate_t;
   typedef enum logic {H_INIT, H_RUN} uie_hstate_t;
   typedef enum logic [2:0] {
      CMD_CFG_B, CMD_MAX_PKT, CMD_STALL_ON, CMD_STALL_OFF,
      CMD_FLUSH, CMD_CLR_UNDER, CMD_CLR_SENT
   } uie_cmd_t;
endpackage

//--- rtl/uie_if.sv
// processor-side connection between the endpoint logic and the processor agent
// assumes both ends share one clock; reads answer one cycle after rd
interface uie_if;
   logic [31:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [7:0]  fifo_data;
   logic        fifo_valid;
   logic        fifo_ready;
   logic        irq;

   modport dev (input addr, wdata, wr, rd, fifo_data, fifo_valid,
                output rdata, fifo_ready, irq);
   modport cpu (output addr, wdata, wr, rd, fifo_data, fifo_valid,
                input rdata, fifo_ready, irq);
endinterface

//--- rtl/uie_fifo.sv
// endpoint data FIFO with valid/ready on both sides
// assumes one clock; out_data is valid whenever out_valid is high
module uie_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_reg;
   logic [AW:0]  rp_reg;
   wire          push = in_valid && in_ready;
   wire          pop  = out_valid && out_ready;

   assign in_ready  = (wp_reg[AW-1:0] != rp_reg[AW-1:0]) || (wp_reg[AW] == rp_reg[AW]);
   assign out_valid = wp_reg != rp_reg;
   assign out_data  = mem[rp_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_reg + (AW+1)'(push);
         rp_reg <= rp_reg + (AW+1)'(pop);
      end
   end
endmodule

//--- rtl/uie_dev.sv
// IN endpoint control/status logic with its packet FIFO
// assumes link logic on the same clock: in_token and usb_ack are one-cycle pulses
// How it works
// - toggle_reset holds DATA0; otherwise toggle alternates on bulk deliveries only
// - stall_request answers tokens with STALL, sets flag
// - STALL handshake clears tx_packet_ready
// - processor sets then clears stall_request
// - flush empties packet, clears request, interrupts
// - flush waits for running transmission
// - flush drops only oldest packet, clears ready
// - iso token without ready sets underrun flag
// - underrun sends empty packet, drops next packet
// - processor clears underrun by writing zero
// - processor sets ready; delivery clears it
// - clearing ready raises interrupt
// - ready set blocks FIFO loading
// - ready cannot be set while stalling
// - auto mode sets ready at max size
// - processor sets ready for short packets
// - periodic_mode_select picks isochronous or bulk
// - direction_select picks IN or OUT, resets IN
// - dma_irq_disable_ctl suppresses ready interrupt
// - registers other than the index answer only when endpoint_select matches
// - max packet size register resets to one
module uie_dev #(
   parameter uie_pkg::uie_byte_t EP_NUM = 8'h01,
   parameter int                 DEPTH  = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   uie_if.dev                bus,
   input  wire logic         in_token,
   input  wire logic         usb_ack,
   output logic              tx_valid,
   output uie_pkg::uie_byte_t tx_data,
   output logic              tx_last,
   output logic              tx_zlp,
   output logic              tx_data1,
   output logic              tx_stall,
   output logic              tx_nak
);
   import uie_pkg::*;
   localparam int CW = $clog2(DEPTH) + 1;

   uie_dstate_t state_reg, state_next;
   uie_byte_t   idx_reg, mpkt_reg, rdata_reg;
   logic [7:4]  csrb_reg;
   logic        tog_reg, ssent_reg, sreq_reg, flush_reg, under_reg, rdy_reg;
   logic        drop_reg, dtog_reg, irq_reg;
   logic [CW-1:0] wcnt_reg, plen_reg, cnt_reg, cnt_next;
   logic        pop, deliver, stall_hit, under_hit, nak, zlp, flush_done, flush_unc;
   logic        txv_n, txl_n;
   logic        f_in_ready, f_out_valid;
   uie_byte_t   f_out_data;

   // decode, banked by endpoint_select
   wire hit    = idx_reg == EP_NUM;
   wire wr_idx = bus.wr && bus.addr == ADDR_INDEX;
   wire wr_mx  = bus.wr && bus.addr == ADDR_MAX_PKT && hit;
   wire wr_a   = bus.wr && bus.addr == ADDR_CSR_A && hit;
   wire wr_b   = bus.wr && bus.addr == ADDR_CSR_B && hit;
   wire iso    = csrb_reg[B_ISO];
   wire [7:0] csr_a = {1'b0, tog_reg, ssent_reg, sreq_reg, flush_reg, under_reg,
                       1'b0, rdy_reg};
   wire [7:0] rd_val = (bus.addr == ADDR_INDEX)       ? idx_reg :
                       (!hit)                         ? 8'h00 :
                       (bus.addr == ADDR_MAX_PKT)     ? mpkt_reg :
                       (bus.addr == ADDR_CSR_A)       ? csr_a :
                       (bus.addr == ADDR_CSR_B)       ? {csrb_reg, 4'h0} : 8'h00;

   // loading is shut while a packet waits and while a flush drains the FIFO
   wire load_ok = !rdy_reg && state_reg != D_FLUSH;
   wire push    = bus.fifo_valid && bus.fifo_ready;
   wire [CW-1:0] wcnt_inc = wcnt_reg + CW'(push);
   wire auto_commit = csrb_reg[B_AUTO] && push && 8'(wcnt_inc) == mpkt_reg;
   wire commit = (wr_a && bus.wdata[B_RDY] || auto_commit) && load_ok
                 && !sreq_reg;
   wire rdy_clr = deliver || stall_hit || flush_done;

   assign bus.fifo_ready = f_in_ready && load_ok;
   assign bus.rdata      = rdata_reg;
   assign bus.irq        = irq_reg;

   uie_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (bus.fifo_valid && load_ok),
      .in_data   (bus.fifo_data),
      .in_ready  (f_in_ready),
      .out_valid (f_out_valid),
      .out_data  (f_out_data),
      .out_ready (pop)
   );

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      pop        = 1'b0;
      deliver    = 1'b0;
      stall_hit  = 1'b0;
      under_hit  = 1'b0;
      nak        = 1'b0;
      zlp        = 1'b0;
      flush_done = 1'b0;
      flush_unc  = 1'b0;
      txv_n      = 1'b0;
      txl_n      = 1'b0;
      unique case (state_reg)
         D_IDLE: begin
            // only entered between transactions, so a flush never cuts a packet
            if (flush_reg || (drop_reg && rdy_reg)) begin
               state_next = D_FLUSH;
               cnt_next   = rdy_reg ? plen_reg : wcnt_inc;
               flush_unc  = !rdy_reg;
            end else if (in_token && csrb_reg[B_DIR]) begin
               if (sreq_reg) begin
                  stall_hit = 1'b1;
               end else if (rdy_reg) begin
                  state_next = D_SEND;
                  cnt_next   = plen_reg;
               end else if (iso) begin
                  under_hit = 1'b1;
                  zlp       = 1'b1;
               end else begin
                  nak = 1'b1;
               end
            end
         end
         D_SEND: begin
            if (cnt_reg == '0) begin
               zlp        = 1'b1;
               deliver    = iso;
               state_next = iso ? D_IDLE : D_WAIT;
            end else if (f_out_valid) begin
               pop      = 1'b1;
               txv_n    = 1'b1;
               txl_n    = cnt_reg == CW'(1);
               cnt_next = cnt_reg - CW'(1);
               if (cnt_reg == CW'(1)) begin
                  deliver    = iso;
                  state_next = iso ? D_IDLE : D_WAIT;
               end
            end
         end
         D_WAIT: begin
            // popped bytes are gone: a retry cannot be replayed
            if (usb_ack) begin
               deliver    = 1'b1;
               state_next = D_IDLE;
            end
         end
         D_FLUSH: begin
            if (cnt_reg == '0) begin
               flush_done = 1'b1;
               state_next = D_IDLE;
            end else if (f_out_valid) begin
               pop      = 1'b1;
               cnt_next = cnt_reg - CW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= D_IDLE;
         cnt_reg   <= '0;
         wcnt_reg  <= '0;
         plen_reg  <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         // a stalled packet turns back into loose bytes, so a later flush still drains it
         wcnt_reg  <= (commit || flush_unc) ? '0 :
                      (stall_hit && rdy_reg) ? plen_reg : wcnt_inc;
         plen_reg  <= commit ? wcnt_inc : plen_reg;
      end
   end

   // software registers; hardware-set flags win over a same-cycle clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idx_reg   <= RST_INDEX;
         mpkt_reg  <= RST_MAX_PKT;
         csrb_reg  <= RST_CSR_B[7:4];
         tog_reg   <= RST_CSR_A[B_TOG];
         sreq_reg  <= RST_CSR_A[B_SREQ];
         ssent_reg <= RST_CSR_A[B_SSENT];
         under_reg <= RST_CSR_A[B_UNDER];
         flush_reg <= RST_CSR_A[B_FLUSH];
         rdy_reg   <= RST_CSR_A[B_RDY];
         drop_reg  <= 1'b0;
      end else begin
         idx_reg   <= wr_idx ? bus.wdata : idx_reg;
         mpkt_reg  <= wr_mx ? bus.wdata : mpkt_reg;
         csrb_reg  <= wr_b ? bus.wdata[7:4] : csrb_reg;
         tog_reg   <= wr_a ? bus.wdata[B_TOG] : tog_reg;
         sreq_reg  <= wr_a ? bus.wdata[B_SREQ] : sreq_reg;
         ssent_reg <= stall_hit || (ssent_reg && !(wr_a && !bus.wdata[B_SSENT]));
         under_reg <= under_hit || (under_reg && !(wr_a && !bus.wdata[B_UNDER]));
         flush_reg <= (wr_a && bus.wdata[B_FLUSH]) || (flush_reg && !flush_done);
         rdy_reg   <= commit || (rdy_reg && !rdy_clr);
         drop_reg  <= under_hit || (drop_reg && !(flush_done && rdy_reg));
      end
   end

   // data toggle, outputs and interrupt
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dtog_reg  <= 1'b0;
         irq_reg   <= 1'b0;
         rdata_reg <= 8'h00;
         tx_valid  <= 1'b0;
         tx_data   <= 8'h00;
         tx_last   <= 1'b0;
         tx_zlp    <= 1'b0;
         tx_data1  <= 1'b0;
         tx_stall  <= 1'b0;
         tx_nak    <= 1'b0;
      end else begin
         dtog_reg  <= !tog_reg && (dtog_reg ^ (deliver && !iso));
         irq_reg   <= (rdy_clr && rdy_reg && !csrb_reg[B_DMAOFF])
                      || (flush_done && flush_reg);
         rdata_reg <= bus.rd ? rd_val : rdata_reg;
         tx_valid  <= txv_n;
         tx_data   <= txv_n ? f_out_data : tx_data;
         tx_last   <= txl_n;
         tx_zlp    <= zlp;
         tx_data1  <= dtog_reg && !tog_reg;
         tx_stall  <= stall_hit;
         tx_nak    <= nak;
      end
   end
endmodule

//--- rtl/uie_cpu.sv
// processor agent: programs the endpoint, loads packets, polls its status
// assumes the endpoint logic on the same clock across uie_if
module uie_cpu #(
   parameter uie_pkg::uie_byte_t EP_NUM = 8'h01
) (
   input  wire logic               clk,
   input  wire logic               nrst,
   uie_if.cpu                      bus,
   input  wire logic               pkt_valid,
   input  wire uie_pkg::uie_byte_t pkt_data,
   input  wire logic               pkt_last,
   output logic                    pkt_ready,
   input  wire logic               cmd_valid,
   input  wire uie_pkg::uie_cmd_t  cmd_code,
   input  wire uie_pkg::uie_byte_t cmd_arg,
   output logic                    cmd_ready,
   output uie_pkg::uie_byte_t      status_a,
   output logic                    ep_event
);
   import uie_pkg::*;
   localparam uie_byte_t KEEP = uie_byte_t'((1 << B_SSENT) | (1 << B_UNDER));

   uie_hstate_t state_reg;
   logic [31:0] addr_reg, c_addr;
   uie_byte_t   wdata_reg, c_data, lcnt_reg, mpkt_sh, status_reg;
   logic        wr_reg, rd_reg, rd_d_reg, cpend_reg, auto_sh, sreq_sh, tog_sh, c_sreq, ev_reg;

   wire run     = state_reg == H_RUN;
   wire load_ok = run && !cpend_reg;
   wire acc     = pkt_valid && pkt_ready;
   wire [7:0] lcnt_inc = lcnt_reg + 8'(acc);
   // in auto mode a full packet is committed by the endpoint itself
   wire auto_hit = auto_sh && acc && lcnt_inc == mpkt_sh;
   wire take_cmd = cmd_valid && cmd_ready;
   wire [7:0] sreq_bit = uie_byte_t'(c_sreq) << B_SREQ;
   wire [7:0] tog_bit  = uie_byte_t'(cmd_arg[B_TOG]) << B_TOG;

   assign pkt_ready      = bus.fifo_ready && load_ok;
   assign cmd_ready      = load_ok;
   assign bus.fifo_valid = pkt_valid && load_ok;
   assign bus.fifo_data  = pkt_data;
   assign bus.addr       = addr_reg;
   assign bus.wdata      = wdata_reg;
   assign bus.wr         = wr_reg;
   assign bus.rd         = rd_reg;
   assign status_a       = status_reg;
   assign ep_event       = ev_reg;

   always_comb begin
      c_sreq = (cmd_code == CMD_STALL_ON) ? 1'b1 :
               (cmd_code == CMD_STALL_OFF) ? 1'b0 : sreq_sh;
      c_addr = ADDR_CSR_A;
      c_data = KEEP;
      unique case (cmd_code)
         CMD_CFG_B: begin
            c_addr = ADDR_CSR_B;
            c_data = cmd_arg;
         end
         CMD_MAX_PKT: begin
            c_addr = ADDR_MAX_PKT;
            c_data = cmd_arg;
         end
         CMD_STALL_ON, CMD_STALL_OFF: c_data = KEEP;
         CMD_FLUSH:     c_data = KEEP | uie_byte_t'(1 << B_FLUSH);
         CMD_CLR_UNDER: c_data = uie_byte_t'(1 << B_SSENT);
         CMD_CLR_SENT:  c_data = uie_byte_t'(1 << B_UNDER);
         default:       c_data = KEEP;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg  <= H_INIT;
         addr_reg   <= ADDR_INDEX;
         wdata_reg  <= 8'h00;
         wr_reg     <= 1'b0;
         rd_reg     <= 1'b0;
         rd_d_reg   <= 1'b0;
         cpend_reg  <= 1'b0;
         lcnt_reg   <= 8'h00;
         auto_sh    <= RST_CSR_B[B_AUTO];
         mpkt_sh    <= RST_MAX_PKT;
         tog_sh     <= RST_CSR_A[B_TOG];
         sreq_sh    <= 1'b0;
         status_reg <= 8'h00;
         ev_reg     <= 1'b0;
      end else begin
         rd_d_reg <= rd_reg;
         ev_reg   <= bus.irq;
         if (rd_d_reg) begin
            status_reg <= bus.rdata;
         end
         if (!run) begin
            state_reg <= H_RUN;
            addr_reg  <= ADDR_INDEX;
            wdata_reg <= EP_NUM;
            wr_reg    <= 1'b1;
            rd_reg    <= 1'b0;
         end else if (cpend_reg) begin
            addr_reg  <= ADDR_CSR_A;
            wdata_reg <= KEEP | uie_byte_t'(1 << B_RDY) | (uie_byte_t'(sreq_sh) << B_SREQ)
                         | (uie_byte_t'(tog_sh) << B_TOG);
            wr_reg    <= 1'b1;
            rd_reg    <= 1'b0;
            cpend_reg <= 1'b0;
         end else if (take_cmd) begin
            addr_reg  <= c_addr;
            wdata_reg <= (c_addr == ADDR_CSR_A) ? (c_data | sreq_bit | tog_bit) : c_data;
            wr_reg    <= 1'b1;
            rd_reg    <= 1'b0;
            sreq_sh   <= c_sreq;
            tog_sh    <= (c_addr == ADDR_CSR_A) ? cmd_arg[B_TOG] : tog_sh;
            auto_sh   <= (cmd_code == CMD_CFG_B) ? cmd_arg[B_AUTO] : auto_sh;
            mpkt_sh   <= (cmd_code == CMD_MAX_PKT) ? cmd_arg : mpkt_sh;
         end else begin
            addr_reg  <= ADDR_CSR_A;
            wr_reg    <= 1'b0;
            rd_reg    <= 1'b1;
         end
         if (acc) begin
            lcnt_reg  <= (pkt_last || auto_hit) ? 8'h00 : lcnt_inc;
            cpend_reg <= pkt_last && !auto_hit;
         end
      end
   end
endmodule

//--- bench/uie_checker.sv
// concurrent checks on the processor bus and the usb pins of the endpoint
// assumes one clock; the bench instantiates it beside the interface
module uie_checker #(
   parameter uie_pkg::uie_byte_t EP_NUM = 8'h01
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [31:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic        fifo_ready,
   input wire logic        irq,
   input wire logic        in_token,
   input wire logic        usb_ack,
   input wire logic        tx_valid,
   input wire logic        tx_last,
   input wire logic        tx_data1,
   input wire logic        tx_stall,
   input wire logic        tx_nak
);
   timeunit 1ns;
   timeprecision 1ps;
   import uie_pkg::*;

   logic idx_ok_reg;
   logic dma_off_reg;
   logic wait_reg;
   wire  wr_b   = wr && addr == ADDR_CSR_B && idx_ok_reg;
   wire  wr_idx = wr && addr == ADDR_INDEX;

   // only the bits the assertions need are shadowed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idx_ok_reg  <= (RST_INDEX == EP_NUM);
         dma_off_reg <= RST_CSR_B[B_DMAOFF];
         wait_reg    <= 1'b0;
      end else begin
         if (wr_idx) idx_ok_reg <= (wdata == EP_NUM);
         if (wr_b) dma_off_reg <= wdata[B_DMAOFF];
         if (tx_last) wait_reg <= 1'b1;
         else if (usb_ack) wait_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_rdata_holds: assert property (!rd |=> $stable(rdata))
      else $error("read data moved without a read");
   a_reserved_a_zero: assert property (rd && addr == ADDR_CSR_A |=>
      rdata[7] == 1'b0 && rdata[1] == 1'b0)
      else $error("reserved status bits read nonzero");
   a_reserved_b_zero: assert property (rd && addr == ADDR_CSR_B |=> rdata[3:0] == 4'h0)
      else $error("reserved config bits read nonzero");
   a_ready_blocks_fifo: assert property (rd && addr == ADDR_CSR_A ##1 rdata[B_RDY]
      |-> $past(fifo_ready) == 1'b0)
      else $error("fifo accepted data while ready bit set");
   a_irq_one_pulse: assert property (irq |=> !irq)
      else $error("interrupt longer than one cycle");
   a_first_byte_lat: assert property ($rose(tx_valid) |-> $past(in_token, 2))
      else $error("first data byte not two cycles after token");
   a_handshake_token: assert property (tx_stall || tx_nak |-> $past(in_token))
      else $error("handshake without a token one cycle before");
   a_stall_no_data: assert property (tx_stall |-> !tx_valid && !tx_nak)
      else $error("stall handshake mixed with data or nak");
   a_last_with_byte: assert property (tx_last |-> tx_valid)
      else $error("last marker without a data byte");
   a_ack_irq: assert property (usb_ack && wait_reg && !dma_off_reg |-> ##1 irq)
      else $error("no interrupt one cycle after delivery");
   a_dma_quiet: assert property (usb_ack && wait_reg && dma_off_reg |-> ##1 !irq)
      else $error("interrupt while dma interrupt disabled");
endmodule

//--- bench/usb_in_endpoint_control_tb.sv
// self-checking bench: processor agent and endpoint joined by uie_if
// assumes one 100 MHz clock; the bench plays the host on the usb pins
module usb_in_endpoint_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uie_pkg::*;

   logic      clk = 1'b0;
   logic      nrst = 1'b0;
   logic      in_token, usb_ack, pkt_valid, pkt_last, cmd_valid;
   uie_byte_t pkt_data, cmd_arg, status_a, tx_data;
   uie_cmd_t  cmd_code;
   logic      pkt_ready, cmd_ready, ep_event, tx_valid, tx_last;
   logic      tx_zlp, tx_data1, tx_stall, tx_nak;
   logic      d1, exp_d1, s_st, s_nk, s_zl;
   int        num_errors = 0;
   int        total_checks = 0;
   int        n_ev = 0;
   int        e0;
   uie_byte_t expq[$];
   uie_byte_t gotq[$];

   uie_if bus_if ();
   uie_dev #(.EP_NUM(8'h01), .DEPTH(8)) i_uie_dev (.clk(clk), .nrst(nrst), .bus(bus_if),
      .in_token(in_token), .usb_ack(usb_ack), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_zlp(tx_zlp), .tx_data1(tx_data1), .tx_stall(tx_stall),
      .tx_nak(tx_nak));
   uie_cpu #(.EP_NUM(8'h01)) i_uie_cpu (.clk(clk), .nrst(nrst), .bus(bus_if),
      .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
      .status_a(status_a), .ep_event(ep_event));
   uie_checker #(.EP_NUM(8'h01)) i_uie_checker (.clk(clk), .nrst(nrst),
      .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
      .rdata(bus_if.rdata), .fifo_ready(bus_if.fifo_ready), .irq(bus_if.irq),
      .in_token(in_token), .usb_ack(usb_ack), .tx_valid(tx_valid), .tx_last(tx_last),
      .tx_data1(tx_data1), .tx_stall(tx_stall), .tx_nak(tx_nak));

   always #5 clk = ~clk;
   always @(posedge clk) if (ep_event === 1'b1) n_ev <= n_ev + 1;

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmd(input uie_cmd_t c, input uie_byte_t a);
      @(posedge clk);
      cmd_code <= c;
      cmd_arg <= a;
      cmd_valid <= 1'b1;
      do @(negedge clk); while (cmd_ready !== 1'b1);
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask

   task automatic load(input int n);
      uie_byte_t b;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         b = 8'($urandom);
         pkt_data <= b;
         pkt_last <= (i == n - 1);
         pkt_valid <= 1'b1;
         do @(negedge clk); while (pkt_ready !== 1'b1);
         expq.push_back(b);
      end
      @(posedge clk);
      pkt_valid <= 1'b0;
      pkt_last <= 1'b0;
   endtask

   // polled status lags the register, so wait with a bound
   task automatic wst(input int p, input logic v);
      int k;
      k = 0;
      while (status_a[p] !== v && k < 300) begin
         @(posedge clk);
         k++;
      end
      chk(status_a[p], v);
   endtask

   task automatic tok;
      gotq = {};
      {s_st, s_nk, s_zl} = 3'b000;
      @(posedge clk);
      in_token <= 1'b1;
      @(posedge clk);
      in_token <= 1'b0;
      repeat (14) begin
         @(negedge clk);
         if (tx_valid === 1'b1) begin
            gotq.push_back(tx_data);
            d1 = tx_data1;
         end
         s_st |= (tx_stall === 1'b1);
         s_nk |= (tx_nak === 1'b1);
         s_zl |= (tx_zlp === 1'b1);
      end
   endtask

   task automatic ack;
      @(posedge clk);
      usb_ack <= 1'b1;
      @(posedge clk);
      usb_ack <= 1'b0;
   endtask

   task automatic xfer(input int n, input bit iso, input int ie);
      int s;
      load(n);
      wst(B_RDY, 1'b1);
      s = n_ev;
      tok;
      chk(8'(gotq.size()), 8'(n));
      foreach (gotq[i]) chk(gotq[i], expq[i]);
      chk(d1, exp_d1);
      expq = {};
      if (!iso) begin
         ack;
         exp_d1 = ~exp_d1;
      end
      wst(B_RDY, 1'b0);
      repeat (4) @(posedge clk);
      chk(8'(n_ev - s), 8'(ie));
   endtask

   initial begin
      {in_token, usb_ack, pkt_valid, pkt_last, cmd_valid} = 5'b0;
      pkt_data = 8'h00;
      cmd_arg = 8'h00;
      cmd_code = CMD_CFG_B;
      exp_d1 = 1'b0;
      void'($urandom(32'h028EF725));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      chk(status_a, RST_CSR_A);
      tok;
      chk(s_nk, 1'b1);
      wst(B_UNDER, 1'b0);
      for (int i = 0; i < 4; i++) xfer(1 + ($urandom % 8), 0, 1);
      xfer(8, 0, 1);
      load(3);
      wst(B_RDY, 1'b1);
      cmd(CMD_STALL_ON, 8'h00);
      tok;
      chk(s_st, 1'b1);
      wst(B_SSENT, 1'b1);
      wst(B_RDY, 1'b0);
      repeat (6) @(posedge clk);
      e0 = n_ev;
      cmd(CMD_FLUSH, 8'h00);
      // polled status lags: let the flush start before waiting for its end
      repeat (20) @(posedge clk);
      wst(B_FLUSH, 1'b0);
      repeat (4) @(posedge clk);
      chk(8'(n_ev - e0), 8'h01);
      load(2);
      repeat (20) @(posedge clk);
      chk(status_a[B_RDY], 1'b0);
      cmd(CMD_STALL_OFF, 8'h00);
      chk(status_a[B_SSENT], 1'b1);
      cmd(CMD_FLUSH, 8'h00);
      cmd(CMD_CLR_SENT, 8'h00);
      wst(B_SSENT, 1'b0);
      expq = {};
      cmd(CMD_CFG_B, 8'h60);
      tok;
      chk(s_zl, 1'b1);
      wst(B_UNDER, 1'b1);
      load(2);
      repeat (30) @(posedge clk);
      chk(status_a[B_RDY], 1'b0);
      expq = {};
      cmd(CMD_CLR_UNDER, 8'h00);
      wst(B_UNDER, 1'b0);
      xfer(4, 1, 1);
      cmd(CMD_CFG_B, 8'hA0);
      cmd(CMD_MAX_PKT, 8'h05);
      xfer(5, 0, 1);
      xfer(2, 0, 1);
      // toggle reset held: packet goes out as DATA0, ack does not flip it
      exp_d1 = 1'b0;
      cmd(CMD_STALL_OFF, 8'h40);
      xfer(2, 0, 1);
      exp_d1 = 1'b0;
      cmd(CMD_STALL_OFF, 8'h00);
      cmd(CMD_CFG_B, 8'h30);
      xfer(3, 0, 0);
      cmd(CMD_CFG_B, 8'h00);
      tok;
      chk({5'b0, s_st, s_nk, s_zl}, 8'h00);
      chk(8'(gotq.size()), 8'h00);
      close_out;
   end

   // whole run needs well under a thousand cycles
   initial begin
      #300000;
      num_errors++;
      close_out;
   end
endmodule
